/* rtl/raioc_pkg.sv */
// Constants, types and helpers for the ramp and auxiliary I/O block
package raioc_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCAN_PERIOD_NS = 100_000_000;
   localparam int SCAN_CYC = SCAN_PERIOD_NS / CLK_PERIOD_NS;
   localparam int RAMP_TICK_NS = 60_000;
   localparam int RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

   // Widths and counts
   localparam int DATA_W = 32;
   localparam int OUT_W = 18;
   localparam int RATE_W = 14;
   localparam int AOUT_W = 16;
   localparam int ADC_W = 20;
   localparam int ACC_W = 20;
   localparam int DIO_W = 5;
   localparam int NAIN = 7;
   localparam int NAOUT = 2;
   localparam int AOUT_VAL_LSB = 8;

   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_RATE = 8'h04;
   localparam logic [7:0] OFS_TARGET = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_OUTPUT = 8'h10;
   localparam logic [7:0] OFS_AIN = 8'h14;
   localparam logic [7:0] OFS_AOUT_SET = 8'h18;
   localparam logic [7:0] OFS_AOUT_Q = 8'h1C;
   localparam logic [7:0] OFS_DOUT = 8'h20;
   localparam logic [7:0] OFS_DIN = 8'h24;

   // Value limits as signed bus words
   localparam logic signed [31:0] W_ZERO = 32'sh00000000;
   localparam logic signed [31:0] W_OUT_MAX = 32'sh000186A0;
   localparam logic signed [31:0] W_OUT_MIN = 32'shFFFE7960;
   localparam logic signed [31:0] W_RATE_MAX = 32'sh00002710;
   localparam logic signed [31:0] W_AOUT_MAX = 32'sh00002710;
   localparam logic signed [31:0] W_AOUT_MIN = 32'shFFFFD8F0;

   // Ramp arithmetic
   localparam logic [OUT_W-1:0] OUT_ONE = 18'h00001;
   localparam logic [ACC_W-1:0] RATE_SCALE = 20'h0000A;
   localparam logic [ACC_W-1:0] ACC_WRAP = 20'hF4240;

   // Selector ranges
   localparam logic [3:0] SEL_FIRST = 4'h1;
   localparam logic [3:0] AIN_LAST = 4'h7;
   localparam logic [3:0] AOUT_LAST = 4'h2;
   localparam logic [3:0] DIO_HI_MAX = 4'h1;
   localparam logic [2:0] CH_FIRST = 3'h1;
   localparam logic [2:0] CH_LAST = 3'h7;

   // ASCII codes
   localparam logic [7:0] ASC_0 = 8'h30;
   localparam logic [7:0] ASC_1 = 8'h31;
   localparam logic [7:0] ASC_9 = 8'h39;
   localparam logic [7:0] ASC_A = 8'h41;
   localparam logic [7:0] ASC_F = 8'h46;
   localparam logic [7:0] HEX_TEN = 8'h0A;

   // Field-setting modes and bus slave states
   typedef enum logic [1:0] {
      MODE_MANUAL = 2'h0,
      MODE_CURRENT = 2'h1,
      MODE_FIELD = 2'h2
   } raioc_mode_t;
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WAIT = 3'b010,
      BUS_DONE = 3'b100
   } raioc_bus_t;

   // ASCII hex digit to {valid, nibble}
   function automatic logic [4:0] raioc_hex_dec(input logic [7:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c >= ASC_0 && c <= ASC_9) begin
         r = {1'b1, 4'(c - ASC_0)};
      end else if (c >= ASC_A && c <= ASC_F) begin
         r = {1'b1, 4'(c - ASC_A + HEX_TEN)};
      end
      return r;
   endfunction : raioc_hex_dec

   // Nibble to upper-case ASCII hex digit
   function automatic logic [7:0] raioc_hex_enc(input logic [3:0] n);
      return (n < 4'hA) ? ASC_0 + {4'h0, n} : ASC_A + {4'h0, n} - HEX_TEN;
   endfunction : raioc_hex_enc

   // Signed range test of a bus word
   function automatic logic raioc_in_rng(input logic [31:0] w,
      input logic signed [31:0] lo, input logic signed [31:0] hi);
      return ($signed(w) >= lo) && ($signed(w) <= hi);
   endfunction : raioc_in_rng
endpackage : raioc_pkg

/* rtl/raioc_scan.sv */
// Auxiliary converter scanner holding the seven latest readings
`timescale 1ns/10ps
module raioc_scan #(
   parameter int SCAN_CYCLES = raioc_pkg::SCAN_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Converter pins
   input wire logic [raioc_pkg::ADC_W-1:0] adc_code,
   output logic [2:0] adc_chan,
   // Reading port
   raioc_scan_if.scan rd
);
   import raioc_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic [2:0] ch;
      logic upd;
      logic [NAIN-1:0][ADC_W-1:0] res;
   } raioc_scan_st_t;

   localparam raioc_scan_st_t SCAN_RST =
      '{cnt: '0, ch: CH_FIRST, upd: 1'b0, res: '0};
   localparam logic [CNT_W-1:0] LAST = CNT_W'(SCAN_CYCLES - 1);

   raioc_scan_st_t s_q;
   raioc_scan_st_t s_d;

   // Converter settles on adc_chan for a whole slot before capture
   always_comb begin
      s_d = s_q;
      s_d.upd = 1'b0;
      if (s_q.cnt == LAST) begin
         s_d.cnt = '0;
         s_d.res[3'(s_q.ch - CH_FIRST)] = adc_code; // R10
         s_d.ch = (s_q.ch == CH_LAST) ? CH_FIRST : s_q.ch + 3'h1; // R9
         s_d.upd = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CNT_ONE;
      end
   end

   // State register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= SCAN_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs; selector outside 1..7 reads zero
   assign adc_chan = s_q.ch;
   assign rd.upd = s_q.upd;
   assign rd.data = (rd.sel >= CH_FIRST && rd.sel <= CH_LAST) ?
      s_q.res[3'(rd.sel - CH_FIRST)] : '0;

   property p_scan_rot;
      @(posedge clk) disable iff (!arst_n)
      s_q.upd |-> adc_chan == (($past(adc_chan) == CH_LAST) ?
         CH_FIRST : $past(adc_chan) + 3'h1);
   endproperty
   a_scan_rot: assert property (p_scan_rot) else $error("bad rotation"); // R9

   property p_scan_store;
      @(posedge clk) disable iff (!arst_n)
      s_q.upd |-> s_q.res[3'($past(adc_chan) - CH_FIRST)] == $past(adc_code);
   endproperty
   a_scan_store: assert property (p_scan_store) else $error("lost code"); // R10
endmodule : raioc_scan

/* rtl/raioc_scan_if.sv */
// Result port between the converter scanner and the command block
`timescale 1ns/10ps
interface raioc_scan_if;
   import raioc_pkg::*;
   logic [2:0] sel;
   logic [ADC_W-1:0] data;
   logic upd;
   modport scan (input sel, output data, output upd);
   modport ctrl (output sel, input data, input upd);
endinterface : raioc_scan_if

/* rtl/raioc_top.sv */
// Ramp control and auxiliary I/O command registers behind AHB-Lite
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
// What this block does
// R1: Status query returns ASCII 1 ramping, 0 idle
// R2: Rate set takes 0 to 100.00 %/min
// R3: No ramp starts while stored rate is zero
// R4: Target set stores value, starts ramp, modes 1-2
// R5: Rate query returns stored rate
// R6: Target query returns destination, not live output
// R7: Set commands give no reply; queries read back
// R8: Input query selects 1 to 7, returns voltage
// R9: One input refreshed each 100 ms, rotating
// R10: Conversion results keep at least 18 bits
// R11: Analog output set: selector 1-2, percent value
// R12: Analog output query returns stored setting
// R13: Digital input query gives two hex digits
// R14: Lines 1-5 map to bits 0-4
// R15: Digital output set drives all five lines
// R16: Line written 1 is released for input
// R17: Digital bitmaps read 00 after reset
// R18: Mode encodes 0 manual, 1 ramp, 2 field
// R19: Manual output write ends ramp, forces value
// R20: Active ramp steps at rate, stops at target
// R21: Out-of-range selectors are ignored
module raioc_top #(
   parameter int SCAN_CYCLES = raioc_pkg::SCAN_CYC,
   parameter int RAMP_CYCLES = raioc_pkg::RAMP_TICK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Field output and auxiliary converters
   output logic [raioc_pkg::OUT_W-1:0] field_out,
   output logic [raioc_pkg::NAOUT-1:0][raioc_pkg::AOUT_W-1:0] aux_dac,
   input wire logic [raioc_pkg::ADC_W-1:0] adc_code,
   output logic [2:0] adc_chan,
   // Shared digital lines
   input wire logic [raioc_pkg::DIO_W-1:0] dio_i,
   output logic [raioc_pkg::DIO_W-1:0] dio_o,
   output logic [raioc_pkg::DIO_W-1:0] dio_oe_n
);
   import raioc_pkg::*;

   typedef struct packed {
      raioc_bus_t bus;
      logic [7:0] addr;
      logic wr;
      logic [DATA_W-1:0] rdata;
      raioc_mode_t mode;
      logic [RATE_W-1:0] rate;
      logic [OUT_W-1:0] target;
      logic [OUT_W-1:0] out;
      logic active;
      logic [ACC_W-1:0] acc;
      logic [CNT_W-1:0] tick;
      logic [NAOUT-1:0][AOUT_W-1:0] aout;
      logic [DIO_W-1:0] dout;
      logic [2:0] ain_sel;
      logic aout_idx;
      logic [DIO_W-1:0] din;
   } raioc_st_t;

   localparam raioc_st_t ST_RST = '{bus: BUS_IDLE, mode: MODE_MANUAL,
      ain_sel: CH_FIRST, default: '0};
   localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(RAMP_CYCLES - 1);

   raioc_st_t s_q;
   raioc_st_t s_d;
   raioc_scan_if scan ();

   logic req;
   logic wr_cyc;
   logic rd_cyc;
   logic [ACC_W-1:0] inc;
   logic [ACC_W:0] sum;
   logic [4:0] d_sel;
   logic [4:0] d_hi;
   logic [4:0] d_lo;
   logic ain_ok;
   logic aout_ok;
   logic [DATA_W-1:0] aval;
   logic [DATA_W-1:0] rmux;

   // Converter scanner
   raioc_scan #(
      .SCAN_CYCLES(SCAN_CYCLES)
   ) u_scan (
      .clk(clk),
      .arst_n(arst_n),
      .adc_code(adc_code),
      .adc_chan(adc_chan),
      .rd(scan.scan)
   );

   // Bus request and data-phase qualifiers
   assign req = hsel && htrans[1] && hready;
   assign wr_cyc = (s_q.bus == BUS_WAIT) && s_q.wr;
   assign rd_cyc = (s_q.bus == BUS_WAIT) && !s_q.wr;
   assign scan.sel = s_q.ain_sel;

   // Read multiplexer; write-only and unmapped words read zero
   always_comb begin
      unique case (s_q.addr)
         OFS_MODE: rmux = DATA_W'(s_q.mode); // R18
         OFS_RATE: rmux = DATA_W'(s_q.rate); // R5
         OFS_TARGET: rmux = DATA_W'($signed(s_q.target)); // R6
         OFS_STATUS: rmux = DATA_W'(s_q.active ? ASC_1 : ASC_0); // R1
         OFS_OUTPUT: rmux = DATA_W'($signed(s_q.out));
         OFS_AIN: rmux = DATA_W'($signed(scan.data)); // R8
         OFS_AOUT_Q: rmux = DATA_W'($signed(s_q.aout[s_q.aout_idx])); // R12
         OFS_DOUT: rmux = {16'h0000, raioc_hex_enc({3'h0, s_q.dout[4]}),
            raioc_hex_enc(s_q.dout[3:0])}; // R14
         OFS_DIN: rmux = {16'h0000, raioc_hex_enc({3'h0, s_q.din[4]}),
            raioc_hex_enc(s_q.din[3:0])}; // R13
         default: rmux = '0; // R7
      endcase
   end

   // Next state: ramp engine first, so a bus write in the same cycle wins
   always_comb begin
      s_d = s_q;
      s_d.din = dio_i;
      inc = ACC_W'(s_q.rate) * RATE_SCALE;
      sum = {1'b0, s_q.acc} + {1'b0, inc};
      d_sel = raioc_hex_dec(hwdata[7:0]);
      d_hi = raioc_hex_dec(hwdata[15:8]);
      d_lo = d_sel;
      ain_ok = d_sel[4] && d_sel[3:0] >= SEL_FIRST && d_sel[3:0] <= AIN_LAST;
      aout_ok = d_sel[4] && d_sel[3:0] >= SEL_FIRST &&
         d_sel[3:0] <= AOUT_LAST;
      aval = {{AOUT_VAL_LSB{hwdata[DATA_W-1]}},
         hwdata[DATA_W-1:AOUT_VAL_LSB]};

      // Ramp tick divider: rate in 0.01 %/min gives 10*rate units of
      // 1e-6 per tick, one output step of 0.001 % per wrap
      if (s_q.tick == TICK_LAST) begin
         s_d.tick = '0;
      end else begin
         s_d.tick = s_q.tick + CNT_ONE;
      end
      if (s_q.active) begin
         if (s_q.out == s_q.target) begin
            s_d.active = 1'b0; // R20
         end else if (s_q.tick == TICK_LAST) begin
            if (sum >= {1'b0, ACC_WRAP}) begin
               s_d.acc = ACC_W'(sum - {1'b0, ACC_WRAP}); // R20
               if ($signed(s_q.target) > $signed(s_q.out)) begin
                  s_d.out = s_q.out + OUT_ONE;
               end else begin
                  s_d.out = s_q.out - OUT_ONE;
               end
            end else begin
               s_d.acc = sum[ACC_W-1:0];
            end
         end
      end

      // Bus slave: one wait state, then the answer stands one cycle
      unique case (s_q.bus)
         BUS_IDLE, BUS_DONE: begin
            if (req) begin
               s_d.bus = BUS_WAIT;
               s_d.addr = haddr[7:0];
               s_d.wr = hwrite;
            end else begin
               s_d.bus = BUS_IDLE;
            end
         end
         BUS_WAIT: begin
            s_d.bus = BUS_DONE;
            if (!s_q.wr) begin
               s_d.rdata = rmux;
            end
         end
         default: begin
            s_d.bus = BUS_IDLE;
         end
      endcase

      // Register writes; out-of-range values leave settings unchanged
      if (wr_cyc) begin
         unique case (s_q.addr)
            OFS_MODE: begin
               if (raioc_in_rng(hwdata, W_ZERO, DATA_W'(MODE_FIELD))) begin
                  s_d.mode = raioc_mode_t'(hwdata[1:0]); // R18
               end
            end
            OFS_RATE: begin
               if (raioc_in_rng(hwdata, W_ZERO, W_RATE_MAX)) begin
                  s_d.rate = hwdata[RATE_W-1:0]; // R2
               end
            end
            OFS_TARGET: begin
               if (raioc_in_rng(hwdata, W_OUT_MIN, W_OUT_MAX)) begin
                  s_d.target = hwdata[OUT_W-1:0]; // R4
                  s_d.acc = '0;
                  // Zero rate or manual mode leaves the output at rest
                  s_d.active = (s_q.rate != '0) && // R3
                     (s_q.mode != MODE_MANUAL) && // R4
                     (hwdata[OUT_W-1:0] != s_q.out);
               end
            end
            OFS_OUTPUT: begin
               if (raioc_in_rng(hwdata, W_OUT_MIN, W_OUT_MAX)) begin
                  s_d.out = hwdata[OUT_W-1:0]; // R19
                  s_d.active = 1'b0; // R19
                  s_d.acc = '0;
               end
            end
            OFS_AIN: begin
               if (ain_ok) begin
                  s_d.ain_sel = d_sel[2:0]; // R21
               end
            end
            OFS_AOUT_SET: begin
               if (aout_ok && raioc_in_rng(aval, W_AOUT_MIN, W_AOUT_MAX)) begin
                  s_d.aout[1'(d_sel[3:0] - SEL_FIRST)] =
                     hwdata[AOUT_VAL_LSB +: AOUT_W]; // R11
               end
            end
            OFS_AOUT_Q: begin
               if (aout_ok) begin
                  s_d.aout_idx = 1'(d_sel[3:0] - SEL_FIRST); // R21
               end
            end
            OFS_DOUT: begin
               if (d_hi[4] && d_lo[4] && d_hi[3:0] <= DIO_HI_MAX) begin
                  s_d.dout = {d_hi[0], d_lo[3:0]}; // R15
               end
            end
            default: begin
               s_d.bus = BUS_DONE; // R7
            end
         endcase
      end
   end

   // State register; lines come up driven low, bitmap 00
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= ST_RST; // R17
      end else begin
         s_q <= s_d;
      end
   end

   // Bus outputs; every answer is OKAY
   assign hreadyout = (s_q.bus != BUS_WAIT);
   assign hrdata = s_q.rdata;
   assign hresp = 1'b0;
   assign field_out = s_q.out;

   // Analog output drivers
   for (genvar g = 0; g < NAOUT; g++) begin : g_dac
      assign aux_dac[g] = s_q.aout[g]; // R11
   end

   // Open-drain lines: a 1 releases the pin so it can be read back
   for (genvar g = 0; g < DIO_W; g++) begin : g_dio
      assign dio_o[g] = 1'b0;
      assign dio_oe_n[g] = s_q.dout[g]; // R16
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   property p_status;
      rd_cyc && s_q.addr == OFS_STATUS |=>
         hrdata == DATA_W'($past(s_q.active) ? ASC_1 : ASC_0);
   endproperty
   a_status: assert property (p_status) else $error("bad status"); // R1

   property p_zero_rate;
      wr_cyc && s_q.addr == OFS_TARGET && s_q.rate == '0 |=> !s_q.active;
   endproperty
   a_zero_rate: assert property (p_zero_rate) else $error("ramp at 0"); // R3

   property p_start;
      wr_cyc && s_q.addr == OFS_TARGET && s_q.rate != '0 &&
      s_q.mode != MODE_MANUAL && hwdata[OUT_W-1:0] != s_q.out &&
      raioc_in_rng(hwdata, W_OUT_MIN, W_OUT_MAX) |=>
         s_q.active && s_q.target == $past(hwdata[OUT_W-1:0]);
   endproperty
   a_start: assert property (p_start) else $error("no ramp start"); // R4

   property p_manual;
      wr_cyc && s_q.addr == OFS_OUTPUT &&
      raioc_in_rng(hwdata, W_OUT_MIN, W_OUT_MAX) |=>
         !s_q.active && field_out == $past(hwdata[OUT_W-1:0]);
   endproperty
   a_manual: assert property (p_manual) else $error("manual fail"); // R19

   property p_done;
      s_q.active && s_q.out == s_q.target && !wr_cyc |=> !s_q.active;
   endproperty
   a_done: assert property (p_done) else $error("ramp not ended"); // R20

   property p_dout;
      rd_cyc && s_q.addr == OFS_DOUT |=>
         hrdata[7:0] == raioc_hex_enc(dio_oe_n[3:0]);
   endproperty
   a_dout: assert property (p_dout) else $error("bitmap mismatch"); // R15

   property p_sel;
      wr_cyc && s_q.addr == OFS_AIN && !ain_ok |=> $stable(s_q.ain_sel);
   endproperty
   a_sel: assert property (p_sel) else $error("bad selector taken"); // R21

   property p_rate;
      s_q.rate <= RATE_W'(W_RATE_MAX);
   endproperty
   a_rate: assert property (p_rate) else $error("rate out of range"); // R2

   property p_wait;
      req && hreadyout |=> !hreadyout ##1 hreadyout;
   endproperty
   a_wait: assert property (p_wait) else $error("bad wait state");

   c_ramp: cover property (s_q.active ##1 !s_q.active);
   c_stop: cover property (s_q.active && wr_cyc && s_q.addr == OFS_OUTPUT);
   c_dout: cover property (wr_cyc && s_q.addr == OFS_DOUT);
   c_scan: cover property (scan.upd);
endmodule : raioc_top

/* verif/raioc_pins_model.sv */
// Pin-side model: auxiliary converter and pulled-up shared digital lines
`timescale 1ns/10ps
module raioc_pins_model (
   // Converter pins
   input wire logic [2:0] adc_chan,
   output logic [raioc_pkg::ADC_W-1:0] adc_code,
   // Shared digital lines
   input wire logic [raioc_pkg::DIO_W-1:0] dio_oe_n,
   input wire logic [raioc_pkg::DIO_W-1:0] ext_low,
   output logic [raioc_pkg::DIO_W-1:0] dio_i
);
   // Result follows the channel, steady through each slot; the upper
   // bits repeat the channel held in the lowest ones so a narrow path would show
   assign adc_code = {adc_chan, 14'h2A5A, adc_chan};
   // Pull-up wins unless the device or the outside world sinks a line
   assign dio_i = dio_oe_n & ~ext_low;
endmodule : raioc_pins_model

/* verif/tb_top.sv */
// Self-checking bench for the ramp and auxiliary I/O block
`timescale 1ns/10ps
module tb_top;
   import raioc_pkg::*;
   logic clk, arst_n, hsel, hwrite, hreadyout, hresp, rdy_s;
   logic [1:0] htrans;
   logic [2:0] hsize, adc_chan;
   logic [31:0] haddr, hwdata, hrdata, rd_s, v;
   logic [OUT_W-1:0] field_out;
   logic [NAOUT-1:0][AOUT_W-1:0] aux_dac;
   logic [ADC_W-1:0] adc_code;
   logic [DIO_W-1:0] dio_i, dio_o, dio_oe_n, ext_low;
   int fail_count, checks;

   // Short counts keep the run brief
   raioc_top #(.SCAN_CYCLES(20), .RAMP_CYCLES(4)) dut (
      .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .field_out(field_out), .aux_dac(aux_dac),
      .adc_code(adc_code), .adc_chan(adc_chan), .dio_i(dio_i),
      .dio_o(dio_o), .dio_oe_n(dio_oe_n));

   raioc_pins_model pins (.adc_chan(adc_chan), .adc_code(adc_code),
      .dio_oe_n(dio_oe_n), .ext_low(ext_low), .dio_i(dio_i));

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Settled copies of the slave answer, taken mid-cycle
   always @(negedge clk) begin
      rdy_s = hreadyout;
      rd_s = hrdata;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : chk

   // Waits for an edge with ready high; a hang ends the run
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy_s !== 1'b1 && n < 100);
      // Only a missing ready counts; ready on the last try is a pass
      if (rdy_s !== 1'b1) begin
         fail_count++;
         results();
      end
   endtask : wait_rdy

   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      r = rd_s;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h00000000, r);
      chk(r, e);
   endtask : rd_chk

   // ASCII hex pair of a five-bit line map
   function automatic logic [31:0] hexa(input logic [4:0] m);
      logic [7:0] lo;
      lo = (m[3:0] < 4'hA) ? 8'h30 + m[3:0] : 8'h37 + m[3:0];
      return {16'h0000, (m[4] ? 8'h31 : 8'h30), lo};
   endfunction : hexa

   task automatic t_reset();
      rd_chk(OFS_MODE, 32'h00000000);
      rd_chk(OFS_RATE, 32'h00000000);
      rd_chk(OFS_TARGET, 32'h00000000);
      rd_chk(OFS_STATUS, 32'h00000030);
      rd_chk(OFS_DOUT, 32'h00003030);
      rd_chk(OFS_DIN, 32'h00003030);
   endtask : t_reset

   task automatic t_mode();
      for (int m = 0; m < 3; m++) begin
         wr(OFS_MODE, 32'(m));
         rd_chk(OFS_MODE, 32'(m));
      end
      wr(OFS_MODE, 32'h00000003);
      rd_chk(OFS_MODE, 32'h00000002);
      wr(OFS_MODE, 32'h00000001);
   endtask : t_mode

   task automatic t_ramp();
      int n;
      wr(OFS_TARGET, 32'h00000005);
      rd_chk(OFS_STATUS, 32'h00000030);
      rd_chk(OFS_TARGET, 32'h00000005);
      wr(OFS_RATE, 32'h00002711);
      rd_chk(OFS_RATE, 32'h00000000);
      wr(OFS_RATE, 32'h00002710);
      rd_chk(OFS_RATE, 32'h00002710);
      wr(OFS_TARGET, 32'h000186A1);
      rd_chk(OFS_TARGET, 32'h00000005);
      wr(OFS_TARGET, 32'h00000003);
      rd_chk(OFS_STATUS, 32'h00000031);
      rd_chk(OFS_OUTPUT, 32'h00000000);
      n = 0;
      // Output climbs one unit per step until it meets the target
      do begin
         xfer(OFS_OUTPUT, 1'b0, 32'h00000000, v);
         n++;
      end while (v !== 32'h00000003 && n < 500);
      chk(v, 32'h00000003);
      // A ramp that never arrives ends the run at the report
      if (v !== 32'h00000003) begin
         results();
      end
      repeat (2) @(posedge clk);
      rd_chk(OFS_STATUS, 32'h00000030);
      chk({14'h0, field_out}, 32'h00000003);
      // A manual write in mid-ramp ends it at once
      wr(OFS_TARGET, 32'hFFFFFFFC);
      rd_chk(OFS_STATUS, 32'h00000031);
      wr(OFS_OUTPUT, 32'h00000001);
      rd_chk(OFS_STATUS, 32'h00000030);
      rd_chk(OFS_OUTPUT, 32'h00000001);
      chk({14'h0, field_out}, 32'h00000001);
   endtask : t_ramp

   task automatic t_ain();
      logic [2:0] ch;
      // Long enough for every slot to have been filled
      repeat (160) @(posedge clk);
      for (int c = 1; c < 8; c++) begin
         ch = 3'(c);
         wr(OFS_AIN, 32'h00000030 + 32'(c));
         rd_chk(OFS_AIN, {{12{ch[2]}}, ch, 14'h2A5A, ch});
      end
      wr(OFS_AIN, 32'h00000038);
      rd_chk(OFS_AIN, {{12{1'b1}}, 3'h7, 14'h2A5A, 3'h7});
   endtask : t_ain

   task automatic t_aout();
      wr(OFS_AOUT_SET, 32'h00271031);
      wr(OFS_AOUT_SET, 32'hFFD8F032);
      chk({16'h0000, aux_dac[0]}, 32'h00002710);
      chk({16'h0000, aux_dac[1]}, 32'h0000D8F0);
      wr(OFS_AOUT_SET, 32'h00000133);
      wr(OFS_AOUT_SET, 32'h00271131);
      wr(OFS_AOUT_Q, 32'h00000031);
      rd_chk(OFS_AOUT_Q, 32'h00002710);
      wr(OFS_AOUT_Q, 32'h00000032);
      rd_chk(OFS_AOUT_Q, 32'hFFFFD8F0);
      wr(OFS_AOUT_Q, 32'h00000033);
      rd_chk(OFS_AOUT_Q, 32'hFFFFD8F0);
      rd_chk(OFS_AOUT_SET, 32'h00000000);
      // Refused writes still answer OKAY, never an error
      chk({31'h0, hresp}, 32'h00000000);
   endtask : t_aout

   task automatic t_dio();
      for (int i = 0; i < 5; i++) begin
         v = 32'h00000001 << i;
         wr(OFS_DOUT, hexa(v[4:0]));
         rd_chk(OFS_DOUT, hexa(v[4:0]));
         chk({27'h0, dio_oe_n}, v);
      end
      wr(OFS_DOUT, 32'h00003147);
      rd_chk(OFS_DOUT, hexa(5'h10));
      // Line 3 held low from outside while all lines are released
      ext_low <= 5'h04;
      wr(OFS_DOUT, 32'h00003146);
      rd_chk(OFS_DIN, hexa(5'h1B));
      wr(OFS_DOUT, 32'h00003030);
      rd_chk(OFS_DIN, 32'h00003030);
      // Open-drain data stays low; only the enables move
      chk({27'h0, dio_o}, 32'h00000000);
   endtask : t_dio

   // Main sequence
   initial begin
      fail_count = 0;
      checks = 0;
      arst_n = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      ext_low = 5'h00;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk({27'h0, dio_oe_n}, 32'h00000000);
      chk({29'h0, adc_chan}, 32'h00000001);
      t_reset();
      t_mode();
      t_ramp();
      t_ain();
      t_aout();
      t_dio();
      results();
   end
endmodule : tb_top
